// ### design/swps_map.vh
// constants for the serial wiper position slave
`ifndef SWPS_MAP_VH
`define SWPS_MAP_VH
`define SWPS_WIPER_W       7
`define SWPS_WIPER_RESET   7'h40
`define SWPS_WIPER_OFFSET  8'h00
`define SWPS_DEV_ADDR      7'h2A
`define SWPS_BIT_LAST      3'h7
`define SWPS_BIT_FIRST     3'h0
`define SWPS_ST_IDLE       3'h0
`define SWPS_ST_RECV       3'h1
`define SWPS_ST_ACK        3'h2
`define SWPS_ST_SEND       3'h3
`define SWPS_ST_MACK       3'h4
`define SWPS_PH_ID         2'h0
`define SWPS_PH_ADDR       2'h1
`define SWPS_PH_DATA       2'h2
`define SWPS_PWRUP_CYCLES  4'hF
`endif

// ### design/swps_serial_wiper_position_slave.v
// two-wire slave that holds and serves the 7-bit wiper position
// Function
// - seven-bit wiper register, 00h low, 7Fh high
// - tap rises monotonically with register value
// - register presets to 40h at reset
// - slave only; master clocks every transfer
// - bytes shifted most significant bit first
// - data changes only while clock low
// - data pin released after power-up
// - ignore bus until start condition seen
// - starts during power-up are ignored
// - ninth clock receiver pulls data low
// - acknowledge valid id, address, write data (a read id is acked only after address zero in the same transfer)
// - id byte: address bits, direction lsb
// - write: start, id, address, data, stop
// - address zero loads data on falling edge
// - no acknowledge for bad id or address
// - keep sending while master acknowledges
`timescale 1ns/10ps
`default_nettype none
`include "swps_map.vh"

module swps_serial_wiper_position_slave #(
    parameter [6:0] DEV_ADDR = `SWPS_DEV_ADDR  // arbitrary neutral address
) (
    input  wire       core_clk,
    input  wire       resetn,
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOut,
    output reg        sdaOe,
    output reg  [6:0] wiperPosition
);

    // transfer states
    localparam [2:0] ST_IDLE = `SWPS_ST_IDLE;
    localparam [2:0] ST_RECV = `SWPS_ST_RECV;
    localparam [2:0] ST_ACK  = `SWPS_ST_ACK;
    localparam [2:0] ST_SEND = `SWPS_ST_SEND;
    localparam [2:0] ST_MACK = `SWPS_ST_MACK;

    // which byte of the transfer is being received
    localparam [1:0] PH_ID   = `SWPS_PH_ID;
    localparam [1:0] PH_ADDR = `SWPS_PH_ADDR;
    localparam [1:0] PH_DATA = `SWPS_PH_DATA;

    // bus pins handled by the synchroniser loop
    localparam       N_PINS  = 2;
    localparam       PIN_SCL = 0;
    localparam       PIN_SDA = 1;

    // pin levels after two flip-flops, and one stage older for edge detection
    wire [N_PINS-1:0] pinIn;
    wire [N_PINS-1:0] syncLvl;
    wire [N_PINS-1:0] prevLvl;

    reg  [3:0]        pwrCount;
    reg  [3:0]        next_pwrCount;
    reg  [6:0]        next_wiperPosition;
    reg  [2:0]        state;
    reg  [1:0]        phase;
    reg  [2:0]        bitCount;
    reg  [7:0]        shiftReg;
    reg  [7:0]        txReg;
    reg               readMode;
    reg               addrOk;
    reg               ackNow;
    reg               byteDone;

    assign pinIn = {sdaIn, sclIn};

    // reset to the pulled-up idle level, so no false edge follows reset
    genvar g;
    generate
        for (g = 0; g < N_PINS; g = g + 1) begin : gSync
            reg stage1;
            reg stage2;
            reg stagePrev;
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    stage1    <= 1'h1;
                    stage2    <= 1'h1;
                    stagePrev <= 1'h1;
                end else begin
                    stage1    <= pinIn[g];
                    stage2    <= stage1;
                    stagePrev <= stage2;
                end
            end
            assign syncLvl[g] = stage2;
            assign prevLvl[g] = stagePrev;
        end
    endgenerate

    wire       sclLvl   = syncLvl[PIN_SCL];
    wire       sdaLvl   = syncLvl[PIN_SDA];
    wire       sclOld   = prevLvl[PIN_SCL];
    wire       sdaOld   = prevLvl[PIN_SDA];

    // both pins pass the same lag, so start and stop keep their order against the clock
    wire       sclRise  = sclLvl & ~sclOld;
    wire       sclFall  = ~sclLvl & sclOld;
    wire       startCnd = sclLvl & sclOld & sdaOld & ~sdaLvl;
    wire       stopCnd  = sclLvl & sclOld & ~sdaOld & sdaLvl;
    wire       pwrDone  = (pwrCount == `SWPS_PWRUP_CYCLES);
    wire [7:0] rxByte   = {shiftReg[6:0], sdaLvl};

    function idMatch;
        input [7:0] b;
        begin
            idMatch = (b[7:1] == DEV_ADDR);
        end
    endfunction

    function isWiperAddr;
        input [7:0] b;
        begin
            isWiperAddr = (b == `SWPS_WIPER_OFFSET);
        end
    endfunction

    function lastBit;
        input [2:0] c;
        begin
            lastBit = (c == `SWPS_BIT_LAST);
        end
    endfunction

    function [7:0] readByte;
        input [6:0] w;
        begin
            readByte = {1'h0, w};
        end
    endfunction

    // power-up window: starts seen before it ends are dropped
    always @* begin
        next_pwrCount = pwrCount;
        if (!pwrDone) begin
            next_pwrCount = pwrCount + 4'h1;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pwrCount <= 4'h0;
        end else begin
            pwrCount <= next_pwrCount;
        end
    end

    // load on the synced fall that closes the data byte; bit 7 is dropped
    wire loadWiper = pwrDone && !startCnd && !stopCnd && (state == ST_RECV)
                     && sclFall && byteDone && (phase == PH_DATA) && addrOk;

    always @* begin
        next_wiperPosition = wiperPosition;
        if (loadWiper) begin
            next_wiperPosition = shiftReg[6:0];
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wiperPosition <= `SWPS_WIPER_RESET;
        end else begin
            wiperPosition <= next_wiperPosition;
        end
    end

    // byteDone marks a finished byte: bitCount alone also reads zero right after a start
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            phase    <= PH_ID;
            bitCount <= `SWPS_BIT_FIRST;
            shiftReg <= 8'h00;
            txReg    <= 8'h00;
            readMode <= 1'h0;
            addrOk   <= 1'h0;
            ackNow   <= 1'h0;
            byteDone <= 1'h0;
            sdaOut   <= 1'h1;
            sdaOe    <= 1'h0;
        end else if (!pwrDone) begin
            state <= ST_IDLE;
            sdaOe <= 1'h0;
        end else if (startCnd) begin
            // repeated start keeps addrOk so a read may follow the address byte
            state    <= ST_RECV;
            phase    <= PH_ID;
            bitCount <= `SWPS_BIT_FIRST;
            byteDone <= 1'h0;
            sdaOe    <= 1'h0;
        end else if (stopCnd) begin
            state  <= ST_IDLE;
            addrOk <= 1'h0;
            sdaOe  <= 1'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sdaOe <= 1'h0;
                end
                ST_RECV: begin
                    if (sclRise) begin
                        shiftReg <= rxByte;
                        bitCount <= bitCount + 3'h1;
                        if (lastBit(bitCount)) begin
                            byteDone <= 1'h1;
                            ackNow   <= 1'h0;
                            case (phase)
                                PH_ID: begin
                                    readMode <= rxByte[0];
                                    if (idMatch(rxByte) && (!rxByte[0] || addrOk)) begin
                                        ackNow <= 1'h1;
                                    end
                                end
                                PH_ADDR: begin
                                    addrOk <= isWiperAddr(rxByte);
                                    ackNow <= isWiperAddr(rxByte);
                                end
                                default: begin
                                    ackNow <= addrOk;
                                end
                            endcase
                        end
                    end else if (sclFall && byteDone) begin
                        // drive only after the fall, so the pin moves while the clock is low
                        byteDone <= 1'h0;
                        state    <= ST_ACK;
                        sdaOut   <= 1'h0;
                        sdaOe    <= ackNow;
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        sdaOe <= 1'h0;
                        if (!ackNow) begin
                            state <= ST_IDLE;
                        end else if (phase == PH_ID && readMode) begin
                            txReg    <= readByte(wiperPosition);
                            sdaOut   <= 1'h0;
                            sdaOe    <= 1'h1;
                            bitCount <= `SWPS_BIT_FIRST;
                            state    <= ST_SEND;
                        end else if (phase == PH_DATA) begin
                            state <= ST_IDLE;
                        end else begin
                            phase <= phase + 2'h1;
                            state <= ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (sclFall) begin
                        bitCount <= bitCount + 3'h1;
                        if (lastBit(bitCount)) begin
                            sdaOe <= 1'h0;
                            state <= ST_MACK;
                        end else begin
                            txReg  <= {txReg[6:0], 1'h0};
                            sdaOut <= txReg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        ackNow <= ~sdaLvl;
                    end else if (sclFall) begin
                        if (ackNow) begin
                            txReg    <= readByte(wiperPosition);
                            sdaOut   <= 1'h0;
                            sdaOe    <= 1'h1;
                            bitCount <= `SWPS_BIT_FIRST;
                            state    <= ST_SEND;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### testbench/swps_properties.sv
// pin-level assertions for the wiper slave
`timescale 1ns/10ps
`default_nettype none
module swps_properties (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic [6:0] wiperPosition
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    chk_preset_mid: assert property ($rose(resetn) |-> wiperPosition == 7'h40)
        else $error("wiper not midscale");
    chk_pin_released: assert property ($rose(resetn) |-> !sdaOe [*8])
        else $error("pin driven at power-up");
    chk_oe_edge_low: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("enable moved with clock high");
    chk_data_edge_low: assert property (sdaOe && $changed(sdaOut) |-> !sclIn)
        else $error("data moved with clock high");
    chk_drive_stands: assert property ($rose(sdaOe) |-> sdaOe [*4])
        else $error("drive too short");
    chk_first_low: assert property ($rose(sdaOe) |-> !sdaOut)
        else $error("ack or msb not low");
    chk_wiper_on_fall: assert property ($changed(wiperPosition)
        |-> !sclIn && !$past(sclIn) && !$past(sclIn, 2))
        else $error("wiper moved off a falling clock");
    chk_quiet_stop: assert property (sclIn && $rose(sdaIn) |-> !sdaOe [*8])
        else $error("driving after stop");
    cover property ($changed(wiperPosition));
    cover property ($rose(sdaOe) && !sdaOut);
    cover property ($fell(sdaOe));
endmodule
bind swps_serial_wiper_position_slave swps_properties chk (.core_clk(core_clk),
    .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .wiperPosition(wiperPosition));
`default_nettype wire

// ### testbench/swps_bus_master.sv
// two-wire bus master model
`timescale 1ns/10ps
`default_nettype none
module swps_bus_master (
    output var logic scl,
    output var logic sda,
    input  wire logic sdaBus
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // data moves 22 ns into the low phase, past the slave's sync lag
    task automatic bitx(input logic b, output logic r);
        sda = b;
        #10 scl = 1'b1;
        #16 r = sdaBus;
        #16 scl = 1'b0;
        #22;
    endtask
    task automatic start;
        sda = 1'b1;
        #10 scl = 1'b1;
        #16 sda = 1'b0;
        #16 scl = 1'b0;
        #22;
    endtask
    task automatic stop;
        sda = 1'b0;
        #10 scl = 1'b1;
        #16 sda = 1'b1;
        #38;
    endtask
    task automatic xfer(input logic [7:0] d, input logic mk, output logic [7:0] q,
                        output logic nk);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(mk, nk);
    endtask
endmodule
`default_nettype wire

// ### testbench/swps_serial_wiper_position_slave_test.sv
// self-checking bench for the wiper slave
`timescale 1ns/10ps
`default_nettype none
`include "swps_map.vh"
`define CHK(nm, e, x) begin checks_done++; if ((x) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, x); end end
module swps_serial_wiper_position_slave_test;
    localparam logic [7:0] IDW = {`SWPS_DEV_ADDR, 1'b0};
    logic       core_clk, resetn, k;
    logic [7:0] seed, d, q0, q1;
    logic [2:0] a;
    int         n_fail, checks_done, cyc;
    wire        scl, sdaM, sdaOut, sdaOe;
    wire  [6:0] wiperPosition;
    wire        sdaBus = sdaM & (~sdaOe | sdaOut);
    swps_bus_master m (.scl(scl), .sda(sdaM), .sdaBus(sdaBus));
    swps_serial_wiper_position_slave dut (.core_clk(core_clk), .resetn(resetn), .sclIn(scl),
        .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .wiperPosition(wiperPosition));
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] readback(input logic [7:0] s);
        return {1'b0, s[6:0]};
    endfunction
    task automatic wr(input logic [7:0] id, input logic [7:0] ad, input logic [7:0] dt);
        m.start;
        m.xfer(id, 1'b1, q0, a[2]);
        m.xfer(ad, 1'b1, q0, a[1]);
        m.xfer(dt, 1'b1, q0, a[0]);
        m.stop;
    endtask
    task automatic rd;
        m.start;
        m.xfer(IDW, 1'b1, q0, a[2]);
        m.xfer(8'h00, 1'b1, q0, a[1]);
        m.start;
        m.xfer(IDW | 8'h01, 1'b1, q0, a[0]);
        m.xfer(8'hFF, 1'b0, q0, k);
        m.xfer(8'hFF, 1'b1, q1, k);
        m.stop;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // run needs about 10000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        resetn = 1'b0;
        seed = 8'h22;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        `CHK("preset", 8'h40, {1'b0, wiperPosition})
        `CHK("released", 1'b0, sdaOe)
        m.start;
        m.xfer(IDW, 1'b1, q0, k);
        m.stop;
        `CHK("early start", 1'b1, k)
        m.scl = 1'b0;
        #40 m.xfer(IDW, 1'b1, q0, k);
        m.stop;
        `CHK("no start", 1'b1, k)
        $display("test reset and power-up done");
        for (int i = 0; i < 9; i++) begin
            d = (i < 4) ? 8'hFF >> (i * 2) : seed;
            seed = nxt(seed);
            wr(IDW, 8'h00, d);
            `CHK("write acks", 3'b000, a)
            `CHK("wiper", readback(d), {1'b0, wiperPosition})
            rd;
            `CHK("read acks", 3'b000, a)
            `CHK("byte one", readback(d), q0)
            `CHK("byte two", readback(d), q1)
        end
        $display("test write and read done");
        wr(IDW ^ 8'h02, 8'h00, 8'h15);
        `CHK("bad id", 3'b111, a)
        wr(IDW, 8'h01, 8'h15);
        `CHK("bad addr", 3'b011, a)
        `CHK("kept", readback(d), {1'b0, wiperPosition})
        $display("test refusals done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
